// >>> design/mcrtc_pkg.sv
/*
 * Constants for the main clock, time-base and beeper unit.
 * Assumes a single divided oscillator clock drives the whole unit.
 */
// Notes on behaviour
// [R01] Slow select clear: cpu clock equals divided oscillator; set: further divided.
// [R02] Prescaler codes 00..11 give divide by 2, 4, 8, 16 in slow mode.
// [R03] Control bit 7 routes divided oscillator clock to the clock-out pin; the code drives the pin at half that rate.
// [R04] Clock-out stops during active-halt even when enabled.
// [R05] Time-base codes give periods of 16000, 32000, 80000, 200000 cycles.
// [R06] New time-base selection waits until the running period completes.
// [R07] Overflow flag bit 0 set on period end, cleared by status read.
// [R08] Overflow interrupt only when enable set and cpu mask inactive.
// [R09] Enable set makes halt instruction enter active-halt, not full halt.
// [R10] Wait mode leaves block running; overflow interrupt wakes from wait.
// [R11] Active-halt: counter runs, registers frozen, overflow wakes device.
// [R12] Halt freezes counter and registers; overflow does not wake from halt.
// [R13] Software avoids bit set/clear on status register; read clears flag.
// [R14] Software writes zeros to reserved bits 7:4 of beep register.
// [R15] Beep register bit 3 drives adc sample-time stretch enable.
// [R16] Beep register bit 2 drives adc interrupt enable.
// [R17] Beeper drives one of three tones or none onto beep pin.
// [R18] Beep codes: off, ~2 kHz, ~1 kHz, ~500 Hz at 8 MHz, half duty.
// [R19] Counter restarts at zero on overflow and loads pending selection there.
package mcrtc_pkg;
    localparam logic [1:0] MCRTC_ADDR_CSR = 2'h0;
    localparam logic [1:0] MCRTC_ADDR_BCR = 2'h1;
    localparam int MCRTC_BIT_CLKOUT = 7;
    localparam int MCRTC_BIT_PRESCALE_LO = 5;
    localparam int MCRTC_BIT_SLOW_SEL = 4;
    localparam int MCRTC_BIT_PERIOD_LO = 2;
    localparam int MCRTC_BIT_OVF_IRQ_EN = 1;
    localparam int MCRTC_BIT_OVF_FLAG = 0;
    localparam int MCRTC_BIT_STRETCH = 3;
    localparam int MCRTC_BIT_ADC_IRQ_EN = 2;
    localparam int MCRTC_BIT_BEEP_LO = 0;
    localparam logic [7:0] MCRTC_CSR_RESET = 8'h00;
    localparam logic [7:0] MCRTC_BCR_RESET = 8'h00;
    localparam logic [3:0] MCRTC_BCR_RSVD_MASK = 4'hf;
    localparam int MCRTC_PERIOD_0 = 16000;
    localparam int MCRTC_PERIOD_1 = 32000;
    localparam int MCRTC_PERIOD_2 = 80000;
    localparam int MCRTC_PERIOD_3 = 200000;
    // Half-periods of the tones at 8 MHz: 2 kHz, 1 kHz, 500 Hz
    localparam int MCRTC_BEEP_H1 = 2000;
    localparam int MCRTC_BEEP_H2 = 4000;
    localparam int MCRTC_BEEP_H3 = 8000;
    localparam logic [31:0] MCRTC_UNMAPPED_DATA = 32'h0000_0000;
    typedef enum logic [1:0] {
        MCRTC_RUN,
        MCRTC_WAIT,
        MCRTC_ACTIVE_HALT,
        MCRTC_HALT
    } mcrtc_power_t;
endpackage

// >>> design/mcrtc_prescaler.sv
/*
 * CPU clock-enable prescaler for slow mode.
 * Assumes ref_clk is the divided oscillator clock; output is an enable pulse.
 */
`timescale 1ns/1ps
module mcrtc_prescaler (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic run,
    input wire logic slow_mode_select,
    input wire logic [1:0] slow_prescaler_sel,
    output logic cpu_clk_en
);
    import mcrtc_pkg::*;

    logic [3:0] div_cnt_reg;
    logic [3:0] div_mask;

    // [R02] Divide codes
    always_comb begin
        case (slow_prescaler_sel)
            2'h0: div_mask = 4'h1;
            2'h1: div_mask = 4'h3;
            2'h2: div_mask = 4'h7;
            default: div_mask = 4'hf;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            div_cnt_reg <= 4'h0;
        end else if (run) begin
            div_cnt_reg <= 4'(div_cnt_reg + 4'h1);
        end
    end

    // [R01] Normal or slow
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            cpu_clk_en <= 1'b0;
        end else if (!run) begin
            cpu_clk_en <= 1'b0;
        end else if (!slow_mode_select) begin
            cpu_clk_en <= 1'b1;
        end else begin
            cpu_clk_en <= ((div_cnt_reg & div_mask) == div_mask);
        end
    end
endmodule

// >>> design/mcrtc_top.sv
/*
 * Main clock controller with time base, clock-out and beeper.
 * Assumes an Avalon-MM master, ref_clk as the divided oscillator clock and
 * power-mode levels supplied by the core's halt sequencing.
 */
`timescale 1ns/1ps
module mcrtc_top #(
    parameter int PERIOD_0 = mcrtc_pkg::MCRTC_PERIOD_0,
    parameter int PERIOD_1 = mcrtc_pkg::MCRTC_PERIOD_1,
    parameter int PERIOD_2 = mcrtc_pkg::MCRTC_PERIOD_2,
    parameter int PERIOD_3 = mcrtc_pkg::MCRTC_PERIOD_3,
    parameter int BEEP_H1 = mcrtc_pkg::MCRTC_BEEP_H1,
    parameter int BEEP_H2 = mcrtc_pkg::MCRTC_BEEP_H2,
    parameter int BEEP_H3 = mcrtc_pkg::MCRTC_BEEP_H3
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire mcrtc_pkg::mcrtc_power_t power_mode,
    input wire logic halt_request,
    input wire logic cpu_irq_mask,
    output logic cpu_clk_en,
    output logic clock_out_pin,
    output logic clock_out_active,
    output logic beep_pin,
    output logic beep_active,
    output logic adc_sample_stretch,
    output logic adc_irq_enable,
    output logic overflow_irq,
    output logic enter_active_halt,
    output logic enter_halt,
    output logic wake_request
);
    import mcrtc_pkg::*;

    // ************************************************************
    // Registers and bus
    // ************************************************************
    logic clock_out_enable_reg;
    logic [1:0] slow_prescaler_sel_reg;
    logic slow_mode_select_reg;
    logic [1:0] time_base_sel_reg;
    logic [1:0] time_base_active_reg;
    logic overflow_irq_enable_reg;
    logic overflow_flag_reg;
    logic adc_sample_stretch_reg;
    logic adc_irq_enable_reg;
    logic [1:0] beep_freq_sel_reg;
    logic ack_reg;
    logic [31:0] readdata_reg;
    logic req;
    logic regs_live;
    logic count_live;
    logic overflow_evt;
    logic csr_read;
    logic [7:0] csr_value;
    logic [7:0] bcr_value;
    logic [17:0] period_cnt_reg;
    logic [17:0] period_limit;
    logic [12:0] beep_cnt_reg;
    logic [12:0] beep_limit;
    logic beep_level_reg;
    logic osc_half_reg;

    // [R11] Registers frozen outside run and wait
    // [R12] Halt freezes counter as well
    assign regs_live = (power_mode == MCRTC_RUN) || (power_mode == MCRTC_WAIT);
    assign count_live = (power_mode != MCRTC_HALT);

    // Answer one cycle after the request, so waitrequest is high for one edge
    assign req = (avs_read || avs_write) && regs_live;
    assign avs_waitrequest = req && !ack_reg;
    assign csr_read = avs_read && ack_reg && (avs_address == MCRTC_ADDR_CSR);

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= req && !ack_reg;
        end
    end

    assign csr_value = {clock_out_enable_reg, slow_prescaler_sel_reg, slow_mode_select_reg,
                        time_base_sel_reg, overflow_irq_enable_reg, overflow_flag_reg};
    // Reserved upper bits always read zero
    assign bcr_value = {4'h0, adc_sample_stretch_reg, adc_irq_enable_reg, beep_freq_sel_reg};

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            readdata_reg <= 32'h0000_0000;
        end else if (avs_read && req && !ack_reg) begin
            if (avs_address == MCRTC_ADDR_CSR) begin
                readdata_reg <= {24'h00_0000, csr_value};
            end else if (avs_address == MCRTC_ADDR_BCR) begin
                readdata_reg <= {24'h00_0000, bcr_value};
            end else begin
                readdata_reg <= MCRTC_UNMAPPED_DATA;
            end
        end
    end
    assign avs_readdata = readdata_reg;

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            clock_out_enable_reg <= MCRTC_CSR_RESET[MCRTC_BIT_CLKOUT];
            slow_prescaler_sel_reg <= MCRTC_CSR_RESET[MCRTC_BIT_PRESCALE_LO +: 2];
            slow_mode_select_reg <= MCRTC_CSR_RESET[MCRTC_BIT_SLOW_SEL];
            time_base_sel_reg <= MCRTC_CSR_RESET[MCRTC_BIT_PERIOD_LO +: 2];
            overflow_irq_enable_reg <= MCRTC_CSR_RESET[MCRTC_BIT_OVF_IRQ_EN];
        end else if (avs_write && ack_reg && avs_byteenable[0]
                     && avs_address == MCRTC_ADDR_CSR) begin
            clock_out_enable_reg <= avs_writedata[MCRTC_BIT_CLKOUT];
            slow_prescaler_sel_reg <= avs_writedata[MCRTC_BIT_PRESCALE_LO +: 2];
            slow_mode_select_reg <= avs_writedata[MCRTC_BIT_SLOW_SEL];
            time_base_sel_reg <= avs_writedata[MCRTC_BIT_PERIOD_LO +: 2];
            overflow_irq_enable_reg <= avs_writedata[MCRTC_BIT_OVF_IRQ_EN];
        end
    end

    // [R14] Reserved bits are not stored
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            adc_sample_stretch_reg <= MCRTC_BCR_RESET[MCRTC_BIT_STRETCH];
            adc_irq_enable_reg <= MCRTC_BCR_RESET[MCRTC_BIT_ADC_IRQ_EN];
            beep_freq_sel_reg <= MCRTC_BCR_RESET[MCRTC_BIT_BEEP_LO +: 2];
        end else if (avs_write && ack_reg && avs_byteenable[0]
                     && avs_address == MCRTC_ADDR_BCR) begin
            adc_sample_stretch_reg <= avs_writedata[MCRTC_BIT_STRETCH];
            adc_irq_enable_reg <= avs_writedata[MCRTC_BIT_ADC_IRQ_EN];
            beep_freq_sel_reg <= avs_writedata[MCRTC_BIT_BEEP_LO +: 2];
        end
    end

    // [R15] Sample stretch out
    assign adc_sample_stretch = adc_sample_stretch_reg;
    // [R16] Converter interrupt enable out
    assign adc_irq_enable = adc_irq_enable_reg;

    // ************************************************************
    // CPU clock prescaler
    // ************************************************************
    mcrtc_prescaler u_prescaler (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .run(regs_live),
        .slow_mode_select(slow_mode_select_reg),
        .slow_prescaler_sel(slow_prescaler_sel_reg),
        .cpu_clk_en(cpu_clk_en)
    );

    // ************************************************************
    // Clock out
    // ************************************************************
    // Pin toggles every cycle, giving half the ref rate as its visible clock
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            osc_half_reg <= 1'b0;
        end else if (clock_out_active) begin
            osc_half_reg <= !osc_half_reg;
        end else begin
            osc_half_reg <= 1'b0;
        end
    end

    // [R03] Route clock to pin
    // [R04] Suspended in active-halt
    assign clock_out_active = clock_out_enable_reg && (power_mode != MCRTC_ACTIVE_HALT)
                              && (power_mode != MCRTC_HALT);
    assign clock_out_pin = osc_half_reg;

    // ************************************************************
    // Time base
    // ************************************************************
    // [R05] Period select
    always_comb begin
        case (time_base_active_reg)
            2'h0: period_limit = 18'(PERIOD_0 - 1);
            2'h1: period_limit = 18'(PERIOD_1 - 1);
            2'h2: period_limit = 18'(PERIOD_2 - 1);
            default: period_limit = 18'(PERIOD_3 - 1);
        endcase
    end

    assign overflow_evt = count_live && (period_cnt_reg == period_limit);

    // [R19] Restart and load selection
    // [R06] Change waits for period end
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            period_cnt_reg <= 18'h0_0000;
            time_base_active_reg <= MCRTC_CSR_RESET[MCRTC_BIT_PERIOD_LO +: 2];
        end else if (overflow_evt) begin
            period_cnt_reg <= 18'h0_0000;
            time_base_active_reg <= time_base_sel_reg;
        end else if (count_live) begin
            period_cnt_reg <= 18'(period_cnt_reg + 18'h0_0001);
        end
    end

    // [R07] Set wins over read clear
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            overflow_flag_reg <= MCRTC_CSR_RESET[MCRTC_BIT_OVF_FLAG];
        end else if (overflow_evt) begin
            overflow_flag_reg <= 1'b1;
        end else if (csr_read) begin
            overflow_flag_reg <= 1'b0;
        end
    end

    // [R08] Gated interrupt request
    assign overflow_irq = overflow_flag_reg && overflow_irq_enable_reg && !cpu_irq_mask;

    // [R09] Halt choice
    assign enter_active_halt = halt_request && overflow_irq_enable_reg;
    assign enter_halt = halt_request && !overflow_irq_enable_reg;

    // [R10] Wake from wait
    // [R12] No wake from halt
    assign wake_request = overflow_irq && (power_mode == MCRTC_WAIT
                                           || power_mode == MCRTC_ACTIVE_HALT);

    // ************************************************************
    // Beeper
    // ************************************************************
    // [R18] Tone half-periods
    always_comb begin
        case (beep_freq_sel_reg)
            2'h1: beep_limit = 13'(BEEP_H1 - 1);
            2'h2: beep_limit = 13'(BEEP_H2 - 1);
            default: beep_limit = 13'(BEEP_H3 - 1);
        endcase
    end

    // [R17] Tone onto beep pin
    assign beep_active = (beep_freq_sel_reg != 2'h0);

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            beep_cnt_reg <= 13'h0000;
            beep_level_reg <= 1'b0;
        end else if (!beep_active || !count_live) begin
            beep_cnt_reg <= 13'h0000;
            beep_level_reg <= 1'b0;
        end else if (beep_cnt_reg >= beep_limit) begin
            beep_cnt_reg <= 13'h0000;
            beep_level_reg <= !beep_level_reg;
        end else begin
            beep_cnt_reg <= 13'(beep_cnt_reg + 13'h0001);
        end
    end
    assign beep_pin = beep_level_reg;
endmodule

// >>> testbench/mcrtc_sva.sv
/* Checker on the ports of mcrtc_top: bus wait, interrupt, wake, halt and clock-out.
   Assumes mcrtc_pkg is compiled first; attached to every mcrtc_top by bind. */
`timescale 1ns/1ps
module mcrtc_sva (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic avs_waitrequest,
    input wire mcrtc_pkg::mcrtc_power_t power_mode,
    input wire logic halt_request,
    input wire logic cpu_irq_mask,
    input wire logic clock_out_pin,
    input wire logic clock_out_active,
    input wire logic overflow_irq,
    input wire logic enter_active_halt,
    input wire logic enter_halt,
    input wire logic wake_request
);
    import mcrtc_pkg::*;
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);
    // ****************************************
    // Properties
    // ****************************************
    property p_irq_mask; overflow_irq |-> !cpu_irq_mask; endproperty
    a_irq_mask: assert property (p_irq_mask) else $error("irq while masked");
    // Flag only falls on a status read and the enable only on a write, so the request must hold otherwise
    property p_irq_hold; overflow_irq && !avs_write && !(avs_read &&
        avs_address == MCRTC_ADDR_CSR) ##1 !cpu_irq_mask |-> overflow_irq; endproperty
    a_irq_hold: assert property (p_irq_hold) else $error("irq dropped early");
    property p_clkout_ah; power_mode == MCRTC_ACTIVE_HALT |-> !clock_out_active; endproperty
    a_clkout_ah: assert property (p_clkout_ah) else $error("clock out in active halt");
    // Pin may finish its last high phase, then must sit low while suspended
    property p_clkout_still; power_mode == MCRTC_ACTIVE_HALT ##1
        power_mode == MCRTC_ACTIVE_HALT |-> !clock_out_pin; endproperty
    a_clkout_still: assert property (p_clkout_still) else $error("pin moves in halt");
    property p_clkout_tgl; clock_out_active |=> clock_out_pin != $past(clock_out_pin);
    endproperty
    a_clkout_tgl: assert property (p_clkout_tgl) else $error("clock out stuck");
    property p_bus_wait; (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
    endproperty
    a_bus_wait: assert property (p_bus_wait) else $error("wait longer than one cycle");
    property p_wake; wake_request == (overflow_irq &&
        power_mode inside {MCRTC_WAIT, MCRTC_ACTIVE_HALT}); endproperty
    a_wake: assert property (p_wake) else $error("wake request wrong");
    property p_enter_src; enter_active_halt || enter_halt |-> halt_request; endproperty
    a_enter_src: assert property (p_enter_src) else $error("halt entry without halt");
    property p_enter_one; !(enter_active_halt && enter_halt); endproperty
    a_enter_one: assert property (p_enter_one) else $error("both halt entries");
    c_irq: cover property (overflow_irq);
    c_wake: cover property (wake_request);
    c_ah: cover property (enter_active_halt);
    c_clkout: cover property (clock_out_active);
endmodule
bind mcrtc_top mcrtc_sva mcrtc_sva_i (.ref_clk, .rst_n, .avs_address, .avs_read, .avs_write,
    .avs_waitrequest, .power_mode, .halt_request, .cpu_irq_mask, .clock_out_pin,
    .clock_out_active, .overflow_irq, .enter_active_halt, .enter_halt, .wake_request);

// >>> testbench/tb_mcrtc_top.sv
/* Self-checking bench for mcrtc_top driven over Avalon-MM.
   Assumes shortened time-base and beep counts; one 50 MHz clock. */
`timescale 1ns/1ps
module tb_mcrtc_top;
    import mcrtc_pkg::*;
    localparam int P [4] = '{16, 32, 80, 200};
    localparam int H [4] = '{0, 2, 4, 8};
    logic ref_clk = 1'b0, rst_n = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
    logic halt_request = 1'b0, cpu_irq_mask = 1'b0;
    logic [1:0] avs_address = 2'h0;
    logic [31:0] avs_writedata = 32'h0;
    logic [3:0] avs_byteenable = 4'h1, be = 4'h1;
    mcrtc_power_t power_mode = MCRTC_RUN;
    logic [31:0] avs_readdata, q;
    logic avs_waitrequest, cpu_clk_en, clock_out_pin, clock_out_active, beep_pin, beep_active;
    logic adc_sample_stretch, adc_irq_enable, overflow_irq, enter_active_halt, enter_halt;
    logic wake_request;
    int fails = 0, total_checks = 0, cyc = 0, t0, t1, g, cnt;
    always #10 ref_clk = ~ref_clk;
    always @(posedge ref_clk) cyc <= cyc + 1;
    mcrtc_top #(.PERIOD_0(P[0]), .PERIOD_1(P[1]), .PERIOD_2(P[2]), .PERIOD_3(P[3]),
        .BEEP_H1(H[1]), .BEEP_H2(H[2]), .BEEP_H3(H[3])) mcrtc_top_i (
        .ref_clk, .rst_n, .avs_address, .avs_read, .avs_write, .avs_writedata,
        .avs_byteenable, .avs_readdata, .avs_waitrequest, .power_mode, .halt_request,
        .cpu_irq_mask, .cpu_clk_en, .clock_out_pin, .clock_out_active, .beep_pin,
        .beep_active, .adc_sample_stretch, .adc_irq_enable, .overflow_irq,
        .enter_active_halt, .enter_halt, .wake_request);
    // ****************************************
    // Shared tasks
    // ****************************************
    task chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Request holds until waitrequest is sampled low at a rising edge; data taken there
    task bus(input logic w, input logic [1:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        avs_address <= a;
        avs_writedata <= {24'h0, d};
        avs_byteenable <= be;
        avs_read <= !w;
        avs_write <= w;
        // Read right after the edge, so the values seen are those the edge sampled
        do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    task nclk(input int k);
        repeat (k) @(negedge ref_clk);
    endtask
    task wait_ovf(output int t);
        int n;
        n = 0;
        do @(negedge ref_clk); while (overflow_irq !== 1'b1 && ++n < 1000);
        t = cyc;
    endtask
    function logic pin(input logic sel);
        return sel ? beep_pin : clock_out_pin;
    endfunction
    // First change only synchronises, so a partial half period is never measured
    task edge_gap(input logic sel);
        logic v;
        int n;
        n = 0;
        @(negedge ref_clk);
        v = pin(sel);
        do @(negedge ref_clk); while (pin(sel) === v && ++n < 100);
        t0 = cyc;
        v = pin(sel);
        do @(negedge ref_clk); while (pin(sel) === v && ++n < 100);
        g = cyc - t0;
    endtask
    // ****************************************
    // Scenarios
    // ****************************************
    task t_regs;
        bus(0, MCRTC_ADDR_CSR, 8'h00);
        chk(q, {24'h0, MCRTC_CSR_RESET});
        bus(0, MCRTC_ADDR_BCR, 8'h00);
        chk(q, {24'h0, MCRTC_BCR_RESET});
        bus(1, 2'h2, 8'hff);
        bus(0, 2'h2, 8'h00);
        chk(q, MCRTC_UNMAPPED_DATA);
        // reserved upper bits always written as zero
        bus(1, MCRTC_ADDR_BCR, 8'h0f);
        bus(0, MCRTC_ADDR_BCR, 8'h00);
        chk(q, 32'h0f);
        nclk(1);
        chk({30'h0, adc_sample_stretch, adc_irq_enable}, 32'h3);
        be = 4'h0;
        bus(1, MCRTC_ADDR_BCR, 8'h00);
        be = 4'h1;
        bus(0, MCRTC_ADDR_BCR, 8'h00);
        chk(q, 32'h0f);
        bus(1, MCRTC_ADDR_BCR, 8'h04);
        nclk(1);
        chk({30'h0, adc_sample_stretch, adc_irq_enable}, 32'h1);
        $display("test regs done");
    endtask
    task t_beep;
        for (int c = 1; c < 4; c++) begin
            bus(1, MCRTC_ADDR_BCR, 8'(c));
            edge_gap(1'b1);
            chk(32'(g), 32'(H[c]));
            chk({31'h0, beep_active}, 32'h1);
        end
        bus(1, MCRTC_ADDR_BCR, 8'h00);
        nclk(1);
        chk({31'h0, beep_active}, 32'h0);
        $display("test beep done");
    endtask
    task t_slow;
        for (int c = 0; c < 5; c++) begin
            bus(1, MCRTC_ADDR_CSR, c < 4 ? 8'h10 | 8'(c << 5) : 8'h00);
            nclk(16);
            cnt = 0;
            repeat (32) begin
                @(negedge ref_clk);
                cnt += int'(cpu_clk_en === 1'b1);
            end
            chk(32'(cnt), c < 4 ? 32'(32 >> (c + 1)) : 32'd32);
        end
        $display("test slow done");
    endtask
    task t_clkout;
        bus(1, MCRTC_ADDR_CSR, 8'h80);
        edge_gap(1'b0);
        chk(32'(g), 32'h1);
        chk({31'h0, clock_out_active}, 32'h1);
        @(posedge ref_clk);
        power_mode <= MCRTC_ACTIVE_HALT;
        nclk(2);
        q = {31'h0, clock_out_pin};
        nclk(4);
        chk({30'h0, clock_out_active, clock_out_pin}, q);
        @(posedge ref_clk);
        power_mode <= MCRTC_RUN;
        bus(1, MCRTC_ADDR_CSR, 8'h00);
        nclk(1);
        chk({31'h0, clock_out_active}, 32'h0);
        $display("test clkout done");
    endtask
    task t_period;
        // status register written whole, never by read-modify-write
        bus(1, MCRTC_ADDR_CSR, 8'h02);
        bus(0, MCRTC_ADDR_CSR, 8'h00);
        wait_ovf(t0);
        bus(0, MCRTC_ADDR_CSR, 8'h00);
        chk(q, 32'h03);
        bus(0, MCRTC_ADDR_CSR, 8'h00);
        chk(q, 32'h02);
        // Each new code is written mid-period, so the old length must still be seen
        for (int c = 1; c < 5; c++) begin
            if (c < 4) bus(1, MCRTC_ADDR_CSR, 8'h02 | 8'(c << 2));
            wait_ovf(t1);
            chk(32'(t1 - t0), 32'(P[c - 1]));
            t0 = t1;
            bus(0, MCRTC_ADDR_CSR, 8'h00);
        end
        $display("test timebase done");
    endtask
    task t_modes;
        @(posedge ref_clk);
        halt_request <= 1'b1;
        nclk(1);
        chk({30'h0, enter_active_halt, enter_halt}, 32'h2);
        bus(1, MCRTC_ADDR_CSR, 8'h0c);
        nclk(1);
        chk({30'h0, enter_active_halt, enter_halt}, 32'h1);
        bus(1, MCRTC_ADDR_CSR, 8'h0e);
        halt_request <= 1'b0;
        wait_ovf(t0);
        @(posedge ref_clk);
        cpu_irq_mask <= 1'b1;
        power_mode <= MCRTC_WAIT;
        nclk(1);
        chk({30'h0, overflow_irq, wake_request}, 32'h0);
        @(posedge ref_clk);
        cpu_irq_mask <= 1'b0;
        nclk(1);
        chk({30'h0, overflow_irq, wake_request}, 32'h3);
        bus(0, MCRTC_ADDR_CSR, 8'h00);
        power_mode <= MCRTC_ACTIVE_HALT;
        wait_ovf(t1);
        chk({31'h0, wake_request}, 32'h1);
        @(posedge ref_clk);
        power_mode <= MCRTC_HALT;
        nclk(1);
        chk({30'h0, overflow_irq, wake_request}, 32'h2);
        @(posedge ref_clk);
        power_mode <= MCRTC_RUN;
        bus(0, MCRTC_ADDR_CSR, 8'h00);
        power_mode <= MCRTC_HALT;
        nclk(400);
        chk({31'h0, overflow_irq}, 32'h0);
        @(posedge ref_clk);
        power_mode <= MCRTC_RUN;
        $display("test modes done");
    endtask
    task wrap_up;
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    initial begin
        repeat (16) @(posedge ref_clk);
        rst_n <= 1'b1;
        t_regs();
        t_beep();
        t_slow();
        t_clkout();
        t_period();
        t_modes();
        wrap_up();
    end
    // Whole run needs under two thousand cycles; this leaves ample margin
    initial begin
        repeat (20000) @(posedge ref_clk);
        fails++;
        wrap_up();
    end
endmodule
